// ### hdl/lock_detect_config.v
// lock detect and output pin configuration registers with lock counter
`include "lock_detect_map.vh"

// Contract
// - lock declared only after programmed count of consecutive in-window edges.
// - timer divide and speed fields apply only in manual mode.
// - enable bit turns lock indicator off or on; set after reset.
// - mode bit: manual when clear, automatic training when set; resets clear.
// - training starts on zero-to-one transition of training bit.
// - pin driver enable clear holds shared pin at high impedance.
// - driver enable set and gpo mode set drives pin always.
// - bias enable bit drives prescaler bias, only for external oscillator path.
// - output level bit selects 1.8 V or supply levels; resets clear.
module lock_detect_config (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // register write and read ports from the serial interface
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [23:0] wr_data,
  input wire [7:0] rd_addr,
  output reg [23:0] rd_data,
  // serial bus context
  input wire [2:0] last_chip_addr,
  input wire gpo_mode,
  input wire serial_out_active,
  input wire serial_out_data,
  // divided oscillator edge events
  input wire div_edge,
  input wire div_edge_in_window,
  input wire ext_osc_sel,
  // lock pin and analog controls
  output wire pin_out,
  output wire pin_oe,
  output wire pin_level_sel,
  output wire prescaler_bias_en,
  output wire high_freq_ref,
  output reg phase_lock_indicator,
  output wire training_busy,
  output wire [2:0] timer_divide,
  output wire [1:0] timer_speed
);

  reg [23:0] lock_cfg_reg;
  reg [23:0] analog_cfg_reg;
  reg train_prev_reg;
  reg [7:0] train_cnt_reg;
  reg [16:0] run_cnt_reg;
  reg [16:0] target;
  wire lock_en;
  wire auto_mode;
  wire train_rise;

  assign lock_en = lock_cfg_reg[`LOCK_EN_BIT];
  assign auto_mode = lock_cfg_reg[`LOCK_MODE_BIT];
  assign train_rise = lock_cfg_reg[`TRAIN_BIT] & ~train_prev_reg;

  // register file; reset values keep lock enabled and manual mode
  always @(posedge clk) begin
    if (sys_rst) begin
      lock_cfg_reg <= `LOCK_CFG_RESET;
      analog_cfg_reg <= `ANALOG_CFG_RESET;
    end else if (wr_en) begin
      if (wr_addr == `LOCK_CFG_ADDR) begin
        lock_cfg_reg <= wr_data;
      end
      if (wr_addr == `ANALOG_CFG_ADDR) begin
        analog_cfg_reg <= wr_data;
      end
    end
  end

  always @* begin
    case (rd_addr)
      `LOCK_CFG_ADDR: rd_data = lock_cfg_reg;
      `ANALOG_CFG_ADDR: rd_data = analog_cfg_reg;
      default: rd_data = 24'h000000;
    endcase
  end

  always @* begin
    case (lock_cfg_reg[`WINCNT_MSB:`WINCNT_LSB])
      3'h0: target = `CNT_5;
      3'h1: target = `CNT_32;
      3'h2: target = `CNT_96;
      3'h3: target = `CNT_256;
      3'h4: target = `CNT_512;
      3'h5: target = `CNT_2048;
      3'h6: target = `CNT_8192;
      3'h7: target = `CNT_65535;
      default: target = `CNT_5;
    endcase
  end

  // training is edge triggered; a held high bit never retrains again
  always @(posedge clk) begin
    if (sys_rst) begin
      train_prev_reg <= 1'b0;
      train_cnt_reg <= 8'h00;
    end else begin
      train_prev_reg <= lock_cfg_reg[`TRAIN_BIT];
      if (train_rise && auto_mode) begin
        train_cnt_reg <= `TRAIN_LEN;
      end else if (train_cnt_reg != 8'h00) begin
        train_cnt_reg <= train_cnt_reg - 8'h01;
      end
    end
  end
  assign training_busy = train_cnt_reg != 8'h00;

  // consecutive run counter; saturates at the target
  always @(posedge clk) begin
    if (sys_rst) begin
      run_cnt_reg <= 17'h00000;
      phase_lock_indicator <= 1'b0;
    end else if (!lock_en || training_busy) begin
      run_cnt_reg <= 17'h00000;
      phase_lock_indicator <= 1'b0;
    end else if (div_edge) begin
      if (!div_edge_in_window) begin
        run_cnt_reg <= 17'h00000;
        phase_lock_indicator <= 1'b0;
      end else if (run_cnt_reg < target) begin
        run_cnt_reg <= run_cnt_reg + 17'h00001;
        phase_lock_indicator <= (run_cnt_reg + 17'h00001) >= target;
      end else begin
        phase_lock_indicator <= 1'b1;
      end
    end
  end

  // manual timer fields are forced to fixed values (divide 4, speed 0) in training mode
  assign timer_divide = auto_mode ? `TDIV_RESET : lock_cfg_reg[`TDIV_MSB:`TDIV_LSB];
  assign timer_speed = auto_mode ? `TSPD_RESET : lock_cfg_reg[`TSPD_MSB:`TSPD_LSB];

  // shared pin: readback data while serial output is active, else lock status
  assign pin_out = serial_out_active ? serial_out_data : phase_lock_indicator;
  assign pin_oe = analog_cfg_reg[`PIN_DRV_EN_BIT] &
    (gpo_mode | (last_chip_addr == 3'h0));
  assign pin_level_sel = analog_cfg_reg[`OUT_LEVEL_BIT];
  assign prescaler_bias_en = analog_cfg_reg[`BIAS_EN_BIT] & ext_osc_sel;
  assign high_freq_ref = analog_cfg_reg[`HF_REF_BIT];

endmodule // lock_detect_config

// ### hdl/lock_detect_map.vh
// register offsets, field positions, reset values and lock counts for the lock detect block
`ifndef LOCK_DETECT_MAP_VH
`define LOCK_DETECT_MAP_VH
`define LOCK_CFG_ADDR 8'h07
`define ANALOG_CFG_ADDR 8'h08
`define LOCK_CFG_RESET 24'h200844
`define ANALOG_CFG_RESET 24'h01bfff
`define WINCNT_LSB 0
`define WINCNT_MSB 2
`define TDIV_LSB 5
`define TDIV_MSB 7
`define TSPD_LSB 8
`define TSPD_MSB 9
`define LOCK_EN_BIT 11
`define LOCK_MODE_BIT 14
`define TRAIN_BIT 20
`define PIN_DRV_EN_BIT 5
`define BIAS_EN_BIT 10
`define HF_REF_BIT 21
`define OUT_LEVEL_BIT 22
`define GPO_MODE_BIT 7
`define CNT_5 17'h00005
`define CNT_32 17'h00020
`define CNT_96 17'h00060
`define CNT_256 17'h00100
`define CNT_512 17'h00200
`define CNT_2048 17'h00800
`define CNT_8192 17'h02000
`define CNT_65535 17'h0ffff
`define TDIV_RESET 3'h4
`define TSPD_RESET 2'h0
`define TRAIN_LEN 8'h3f
`endif

// ### tb/lock_detect_config_checker.sv
// port assertions for the lock detect block
module lock_detect_config_checker (
  input wire clk, sys_rst, gpo_mode, div_edge, div_edge_in_window, ext_osc_sel, pin_oe,
  input wire pin_level_sel, prescaler_bias_en, phase_lock_indicator, training_busy,
  input wire [7:0] rd_addr,
  input wire [23:0] rd_data,
  input wire [2:0] last_chip_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  // register view is valid only while the bench reads 08h
  wire s8 = rd_addr == 8'h08;
  wire lk = phase_lock_indicator;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_pin_hiz: assert property (s8 && !rd_data[5] |-> !pin_oe) else $error("hiz");
  a_gpo_drive: assert property (s8 && rd_data[5] && gpo_mode |-> pin_oe) else $error("gpo");
  a_bus_release: assert property (s8 && rd_data[5] && !gpo_mode |-> pin_oe == (last_chip_addr == 3'h0))
    else $error("rel");
  a_bias_gate: assert property (s8 |-> prescaler_bias_en == (rd_data[10] && ext_osc_sel)) else $error("bias");
  a_level_sel: assert property (s8 |-> pin_level_sel == rd_data[22]) else $error("lvl");
  a_lock_drop: assert property (div_edge && !div_edge_in_window |=> !lk) else $error("drop");
  a_lock_cause: assert property ($rose(lk) |-> $past(div_edge) && $past(div_edge_in_window)) else $error("rise");
  a_train_run: assert property ($rose(training_busy) |-> training_busy[*8] ##0 !lk) else $error("train");
  cover property ($rose(lk));
  cover property ($rose(training_busy));
  cover property (s8 && gpo_mode && pin_oe);
endmodule // lock_detect_config_checker
bind lock_detect_config lock_detect_config_checker lock_detect_config_checker_inst (.*);

// ### tb/host_ctl.sv
// host controller model writing the configuration registers
module host_ctl #(parameter int xtal_mhz = 50) (
  input wire clk,
  output logic wr_en = 0,
  output logic [7:0] wr_addr = 8'h00,
  output logic [23:0] wr_data = 24'h000000
);
  timeunit 1ns;
  timeprecision 1ns;
  task put(input [7:0] a, input [23:0] d);
    @(posedge clk) wr_en <= 1;
    wr_addr <= a;
    wr_data <= a == 8'h07 ? d & 24'hd0cbe7 | 24'h200000 : {d[23:22], xtal_mhz > 200, d[20:0]};
    @(posedge clk) wr_en <= 0;
    // released data must not keep looking valid
    wr_data <= ~wr_data;
    #1;
  endtask
  task retrain(input [23:0] d);
    put(8'h07, d & 24'hefffff);
    put(8'h07, d | 24'h100000);
  endtask
endmodule // host_ctl

// ### tb/lock_detect_config_tb_top.sv
// self-checking bench for the lock detect block
module lock_detect_config_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, sys_rst = 1, gpo_mode = 0, div_edge = 0, div_edge_in_window = 0, ext_osc_sel = 1;
  logic serial_out_active = 0, serial_out_data = 0;
  logic [7:0] rd_addr = 8'h07;
  logic [2:0] last_chip_addr = 3'h0;
  wire wr_en, pin_out, pin_oe, pin_level_sel, prescaler_bias_en, high_freq_ref, phase_lock_indicator, training_busy;
  wire [7:0] wr_addr;
  wire [23:0] wr_data, rd_data;
  wire [2:0] timer_divide;
  wire [1:0] timer_speed;
  int err_total = 0, num_checks = 0, n;
  int cnt[7] = '{5, 32, 96, 256, 512, 2048, 8192};
  always #10 clk = ~clk;
  lock_detect_config lock_detect_config_inst (.*);
  host_ctl host_ctl_inst (.*);
  task chk(input [23:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task edges(input int k, input logic w);
    repeat (k) begin
      @(posedge clk) div_edge <= 1;
      div_edge_in_window <= w;
      @(posedge clk) div_edge <= 0;
    end
    #1;
  endtask
  task t_lock;
    chk(rd_data, 24'h200844);
    rd_addr <= 8'h08;
    // a leftover run would lock early at the next code
    for (int c = 0; c < 7; c++) begin
      host_ctl_inst.put(8'h07, 24'h200800 + 24'(c));
      edges(1, 0);
      edges(cnt[c] - 1, 1);
      chk(phase_lock_indicator, 0);
      edges(1, 1);
      chk(phase_lock_indicator, 1);
    end
    $display("lock done");
  endtask
  task t_train;
    host_ctl_inst.put(8'h07, 24'h200be0);
    chk({timer_speed, timer_divide}, 5'h1f);
    for (int r = 0; r < 2; r++) begin
      if (r == 0) host_ctl_inst.retrain(24'h204be0);
      else host_ctl_inst.put(8'h07, 24'h304be0);
      chk({timer_speed, timer_divide}, 5'h04);
      n = 0;
      repeat (150) @(posedge clk) #1 n += training_busy;
      chk(n, r ? 0 : 63);
    end
    $display("train done");
  endtask
  task t_pin;
    chk(rd_data, 24'h01bfff);
    host_ctl_inst.put(8'h08, 24'h01bfdf);
    chk(pin_oe, 0);
    host_ctl_inst.put(8'h08, 24'h41bfff);
    chk({pin_level_sel, pin_oe}, 2'h3);
    @(posedge clk) last_chip_addr <= 3'h5;
    #1 chk(pin_oe, 0);
    @(posedge clk) gpo_mode <= 1;
    #1 chk(pin_oe, 1);
    // lock from the last count code is still held, so the pin shows it
    chk(pin_out, 1);
    @(posedge clk) serial_out_active <= 1;
    #1 chk(pin_out, 0);
    @(posedge clk) serial_out_data <= 1;
    #1 chk(pin_out, 1);
    @(posedge clk) serial_out_active <= 0;
    @(posedge clk) ext_osc_sel <= 0;
    #1 chk({high_freq_ref, prescaler_bias_en}, 0);
    $display("pin done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 0;
    #1 t_lock;
    t_pin;
    t_train;
    end_sim;
  end
endmodule // lock_detect_config_tb_top
